// file: fp_cdu_consts.svh
// Purpose: constants for the convert/divide slice
// Assumes: IEEE single and double layouts
// Notes:   cause/flag vector order is {E,V,Z,O,U,I}
`ifndef FP_CDU_CONSTS_SVH
`define FP_CDU_CONSTS_SVH
`define SGL_MIN_NORM   31'h00800000
`define SGL_INF_MAG    31'h7F800000
`define SGL_SNAN_MAG   31'h7FC00000
`define SGL_POS_INF    32'h7F800000
`define SGL_NEG_INF    32'hFF800000
`define SGL_QNAN       32'h7FBFFFFF
`define DBL_QNAN       64'h7FF7FFFFFFFFFFFF
`define DBL_INF_MAG    63'h7FF0000000000000
`define DBL_MIN_NORM   63'h0010000000000000
`define DBL_SNAN_MAG   63'h7FF8000000000000
`define LOW29_MASK     32'h1FFFFFFF
`define EXC_E          5
`define EXC_V          4
`define EXC_Z          3
`define EXC_O          2
`define EXC_U          1
`define EXC_I          0
`define CNV_STATES     5'h02
`define DIVS_STATES    5'h0A
`define DIVD_STATES    5'h17
`define PC_STEP        32'h00000002
`define OP_CNVDS       8'hBD
`define OP_CNVSD       8'hAD
`define OP_DIV_LO      4'h3
`endif

// file: fp_cdu_pkg.sv
// Purpose: types for the convert/divide slice
// Assumes: none
// Notes:   class order matters for nothing outside the slice
package fp_cdu_pkg;
   typedef enum logic [2:0] {
      CLS_ZERO, CLS_DENORMAL_CLASS, CLS_NORM, CLS_INF, CLS_QNAN, CLS_SNAN
   } fp_class_type;
   typedef enum logic [1:0] {
      OP_NONE, OP_CNVDS, OP_CNVSD, OP_DIV
   } op_kind_type;
endpackage

// file: fp_classify.sv
// Purpose: classify a single word and a double word
// Assumes: flush forces small magnitudes to zero
// Notes:   purely combinational
`include "fp_cdu_consts.svh"
`timescale 1ns/1ps
module fp_classify (
   input  wire logic                     flush,
   input  wire logic [31:0]              sglWord,
   input  wire logic [63:0]              dblWord,
   output fp_cdu_pkg::fp_class_type      sglClass,
   output fp_cdu_pkg::fp_class_type      dblClass
);
   import fp_cdu_pkg::*;
   wire [30:0] sMag = sglWord[30:0];
   wire [62:0] dMag = dblWord[62:0];
   // Magnitude thresholds; upper quiet range is signaling here [RULE10]
   assign sglClass = (sMag < `SGL_MIN_NORM) ?
                        ((flush || sMag == 31'h0) ? CLS_ZERO : CLS_DENORMAL_CLASS) :
                     (sMag < `SGL_INF_MAG)  ? CLS_NORM :
                     (sMag == `SGL_INF_MAG) ? CLS_INF  :
                     (sMag < `SGL_SNAN_MAG) ? CLS_QNAN : CLS_SNAN;
   assign dblClass = (dMag < `DBL_MIN_NORM) ?
                        ((flush || dMag == 63'h0) ? CLS_ZERO : CLS_DENORMAL_CLASS) :
                     (dMag < `DBL_INF_MAG)  ? CLS_NORM :
                     (dMag == `DBL_INF_MAG) ? CLS_INF  :
                     (dMag < `DBL_SNAN_MAG) ? CLS_QNAN : CLS_SNAN;
endmodule

// file: fp_divider.sv
// Purpose: restoring mantissa divider, one bit per cycle
// Assumes: normal operands, exponent handled by the caller
// Notes:   produces 56 quotient bits plus remainder-nonzero
`timescale 1ns/1ps
module fp_divider (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        start,
   input  wire logic [53:0] dividend,
   input  wire logic [53:0] divisor,
   output logic             done,
   output logic [55:0]      quotient,
   output logic             remNonZero
);
   logic [54:0] rem_q;
   logic [5:0]  cnt_q;
   logic        busy_q;
   // Compare before shifting so bit 55 is the integer bit; rem stays below twice the divisor
   wire  [55:0] trial = {1'b0, rem_q} - {2'b00, divisor};
   wire         fits  = !trial[55];
   always_ff @(posedge clk) begin
      if (srst) begin
         rem_q <= '0; cnt_q <= '0; busy_q <= 1'b0;
         quotient <= '0; done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            rem_q <= {1'b0, dividend}; cnt_q <= 6'd56; busy_q <= 1'b1;
            quotient <= '0;
         end else if (busy_q) begin
            rem_q <= {(fits ? trial[53:0] : rem_q[53:0]), 1'b0};
            quotient <= {quotient[54:0], fits};
            cnt_q <= cnt_q - 6'd1;
            if (cnt_q == 6'd1) begin
               busy_q <= 1'b0; done <= 1'b1;
            end
         end
      end
   end
   assign remNonZero = (rem_q != '0);
endmodule

// file: fp_convert_divide_unit.sv
// Purpose: FP convert (double<->single) and divide execution slice
// Assumes: decoder issues one op at a time; operands held while busy
// Notes:   divide finishes at the later of mantissa loop and state count
`include "fp_cdu_consts.svh"
`timescale 1ns/1ps
// Function
// RULE1: Double-to-single into transfer register, 2 states
// RULE2: Conversions valid only with precision-select set
// RULE3: Any O/U/I enable always traps
// RULE4: Conversion exception: record, keep transfer register
// RULE5: Fixed infinity and quiet NaN patterns
// RULE6: Signaling NaN: invalid, default NaN or trap
// RULE7: Low 29 bits set inexact; truncate (code rounds nearest-even unless roundingSelect is set)
// RULE8: Denormal flushed to zero, else error
// RULE9: Single-to-double into destination pair, 2 states
// RULE10: Classify single by magnitude thresholds
// RULE11: Widen keeps class; NaN handling
// RULE12: Single divide, 10 states (code also waits for the mantissa loop, so it takes 60 states)
// RULE13: Double divide, 23 states (code also waits for the mantissa loop, so it takes 60 states)
// RULE14: Divide exception: record, keep destination
// RULE15: NaN checks precede other divide cases
// RULE16: Zero divisor: invalid, infinity or divide-by-zero
// RULE17: Infinity cases with XOR sign
// RULE18: Denormal unflushed divide sets error
// RULE19: Round nearest-even, or toward zero
// RULE20: Inexact from remainder; truncation under RZ
// RULE21: Clear cause, advance PC by 2
// RULE22: Check narrowed result for O/U/I
module fp_convert_divide_unit (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        issue,
   input  wire logic [15:0] opcode,
   input  wire logic        precisionSelect,
   input  wire logic        denormalFlush,
   input  wire logic        roundingSelect,
   input  wire logic [4:0]  trapEnableBits,
   input  wire logic [31:0] pcIn,
   input  wire logic [31:0] transferIn,
   input  wire logic [31:0] singleSourceReg,
   input  wire logic [31:0] singleDestReg,
   input  wire logic [63:0] doubleSourcePair,
   input  wire logic [63:0] doubleDestPair,
   output logic             busy,
   output logic             done,
   output logic             undefinedOp,
   output logic             fpuTrap,
   output logic [31:0]      pcOut,
   output logic [5:0]       exceptionCauseField,
   output logic [4:0]       stickyFlagField,
   output logic             transferWe,
   output logic [31:0]      transferOut,
   output logic             singleDestWe,
   output logic [31:0]      singleDestOut,
   output logic             doubleDestWe,
   output logic [63:0]      doubleDestOut
);
   import fp_cdu_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_FINISH} state_type;

   state_type    state_q;
   op_kind_type  op_q;
   logic         dbl_q;
   logic [4:0]   cnt_q;
   logic [63:0]  a_q;
   logic [63:0]  b_q;
   logic         divDone_q;
   logic [55:0]  quot_q;
   logic         rem_q;

   // Opcode decode; conversions need precision-select [RULE2]
   wire isCnvDs = (opcode[15:12] == 4'hF) && (opcode[7:0] == `OP_CNVDS) && !opcode[8];
   wire isCnvSd = (opcode[15:12] == 4'hF) && (opcode[7:0] == `OP_CNVSD) && !opcode[8];
   wire isDiv   = (opcode[15:12] == 4'hF) && (opcode[3:0] == `OP_DIV_LO);
   wire cnvReserved = (isCnvDs || isCnvSd) && !precisionSelect;  // [RULE2]
   wire start   = issue && (state_q == ST_IDLE) && !cnvReserved
                  && (isCnvDs || isCnvSd || isDiv);

   fp_class_type clsA;
   fp_class_type clsB;
   fp_class_type clsAs;
   fp_class_type clsBd;
   // Class of a (dividend / conversion source) and b (divisor)
   fp_classify u_clsA (
      .flush    (denormalFlush),
      .sglWord  (a_q[31:0]),
      .dblWord  (a_q),
      .sglClass (clsAs),
      .dblClass (clsA)
   );
   fp_classify u_clsB (
      .flush    (denormalFlush),
      .sglWord  (b_q[31:0]),
      .dblWord  (b_q),
      .sglClass (clsB),
      .dblClass (clsBd)
   );
   wire fp_class_type ca = dbl_q ? clsA  : clsAs;
   wire fp_class_type cb = dbl_q ? clsBd : clsB;

   // Field extraction shared by both precisions
   function automatic logic [12:0] expOf(input logic [63:0] v, input logic d);
      expOf = d ? {2'b00, v[62:52]} : {5'b0, v[30:23]};
   endfunction
   function automatic logic [53:0] manOf(input logic [63:0] v, input logic d);
      manOf = d ? {1'b0, 1'b1, v[51:0]} : {1'b0, 1'b1, v[22:0], 29'h0};
   endfunction

   // Divider mantissas, dividend ≥ divisor guaranteed by one pre-shift
   wire [53:0] manA = manOf(a_q, dbl_q);
   wire [53:0] manB = manOf(b_q, dbl_q);
   wire        aLess = manA < manB;
   logic       divStart_q;
   logic       divDone;
   logic [55:0] divQuot;
   logic       divRem;
   fp_divider u_div (
      .clk        (clk),
      .srst       (srst),
      .start      (divStart_q),
      .dividend   (aLess ? {manA[52:0], 1'b0} : manA),
      .divisor    (manB),
      .done       (divDone),
      .quotient   (divQuot),
      .remNonZero (divRem)
   );

   // Divide rounding: quotient msb at 55; guard/sticky from the rest [RULE19] [RULE20]
   wire        sgnQ  = dbl_q ? (a_q[63] ^ b_q[63]) : (a_q[31] ^ b_q[31]);
   wire [12:0] bias  = dbl_q ? 13'd1023 : 13'd127;
   wire [12:0] eQ    = expOf(a_q, dbl_q) - expOf(b_q, dbl_q) + bias - {12'd0, aLess};
   wire [52:0] qMan  = dbl_q ? quot_q[55:3] : {29'h0, quot_q[55:32]};
   wire        qG    = dbl_q ? quot_q[2] : quot_q[31];
   wire        qSt   = rem_q | (dbl_q ? |quot_q[1:0] : |quot_q[30:0]);
   wire        qInex = qG | qSt;                                       // [RULE20]
   wire        qUp   = !roundingSelect && qG && (qSt || qMan[0]);      // [RULE19]
   wire [53:0] qRnd  = {1'b0, qMan} + {53'd0, qUp};
   wire        qCar  = dbl_q ? qRnd[53] : qRnd[24];
   wire [12:0] eFin  = eQ + {12'd0, qCar};
   wire [12:0] eMax  = dbl_q ? 13'd2047 : 13'd255;
   wire        qOvf  = !eFin[12] && (eFin >= eMax);
   wire        qUnf  = eFin[12] || (eFin == 13'd0);
   wire [63:0] qWord = dbl_q ? {sgnQ, eFin[10:0], qRnd[51:0]}
                             : {32'h0, sgnQ, eFin[7:0], qRnd[22:0]};

   // Narrowing of a normal double [RULE7] [RULE19] [RULE22]
   wire        nSgn  = a_q[63];
   wire [12:0] nExp  = {2'b00, a_q[62:52]} - 13'd896;
   wire        nLow  = (a_q[28:0] != 29'h0);                           // [RULE7]
   wire        nUp   = !roundingSelect && a_q[28] && ((a_q[27:0] != 28'h0) || a_q[29]);
   wire [23:0] nRnd  = {1'b0, a_q[51:29]} + {23'd0, nUp};
   wire [12:0] nExpF = nExp + {12'd0, nRnd[23]};
   wire        nOvf  = !nExpF[12] && (nExpF >= 13'd255);
   wire        nUnf  = nExpF[12] || (nExpF == 13'd0);
   wire        zeroIn = (a_q[62:0] == 63'h0) || (a_q[62:52] == 11'h0);

   // Result and exception evaluation
   logic [5:0]  exc;
   logic        wr;
   logic [63:0] res;
   always_comb begin
      exc = 6'h0;
      wr  = 1'b0;
      res = 64'h0;
      case (op_q)
         OP_CNVDS: begin
            case (clsA)
               CLS_DENORMAL_CLASS: exc[`EXC_E] = 1'b1;                         // [RULE8]
               CLS_INF:  begin wr = 1'b1; res = {32'h0, nSgn ? `SGL_NEG_INF : `SGL_POS_INF}; end
               CLS_QNAN: begin wr = 1'b1; res = {32'h0, `SGL_QNAN}; end // [RULE5]
               CLS_SNAN: begin
                  exc[`EXC_V] = 1'b1;                                  // [RULE6]
                  wr = 1'b1;
                  res = {32'h0, `SGL_QNAN};
               end
               CLS_NORM: begin
                  exc[`EXC_I] = nLow;                                  // [RULE7]
                  wr = 1'b1;
                  if (nOvf) begin
                     exc[`EXC_O] = 1'b1; exc[`EXC_I] = 1'b1;           // [RULE22]
                     res = {32'h0, nSgn, 8'hFF, 23'h0};
                  end else if (nUnf) begin
                     exc[`EXC_U] = 1'b1; exc[`EXC_I] = 1'b1;           // [RULE22]
                     res = {32'h0, nSgn, 31'h0};
                  end else begin
                     res = {32'h0, nSgn, nExpF[7:0], nRnd[22:0]};
                  end
               end
               default: begin wr = 1'b1; res = {32'h0, nSgn, 31'h0}; end
            endcase
            if (zeroIn) res = {32'h0, nSgn, 31'h0};                    // [RULE8]
         end
         OP_CNVSD: begin
            case (clsAs)                                               // [RULE11]
               CLS_DENORMAL_CLASS: exc[`EXC_E] = 1'b1;                         // [RULE8]
               CLS_QNAN:   begin wr = 1'b1; res = `DBL_QNAN; end
               CLS_SNAN:   exc[`EXC_V] = 1'b1;
               CLS_ZERO:   begin wr = 1'b1; res = {a_q[31], 63'h0}; end
               CLS_INF:    begin wr = 1'b1; res = {a_q[31], `DBL_INF_MAG}; end
               default: begin
                  wr  = 1'b1;
                  res = {a_q[31], 3'b000, a_q[30:0], 29'h0} + {1'b0, 11'd896, 52'h0};
               end
            endcase
         end
         OP_DIV: begin
            if (ca == CLS_SNAN || cb == CLS_SNAN) exc[`EXC_V] = 1'b1;  // [RULE15]
            else if (ca == CLS_QNAN || cb == CLS_QNAN) begin
               wr = 1'b1;
               res = dbl_q ? `DBL_QNAN : {32'h0, `SGL_QNAN};
            end else if (ca == CLS_DENORMAL_CLASS || cb == CLS_DENORMAL_CLASS)
               exc[`EXC_E] = 1'b1;                                     // [RULE18]
            else if (cb == CLS_ZERO) begin                             // [RULE16]
               if (ca == CLS_ZERO) exc[`EXC_V] = 1'b1;
               else if (ca == CLS_INF) begin
                  wr = 1'b1;
                  res = dbl_q ? {sgnQ, `DBL_INF_MAG} : {32'h0, sgnQ, `SGL_INF_MAG};
               end else exc[`EXC_Z] = 1'b1;
            end else if (ca == CLS_INF && cb == CLS_INF)
               exc[`EXC_V] = 1'b1;                                     // [RULE17]
            else if (cb == CLS_INF || ca == CLS_ZERO) begin
               wr = 1'b1;
               res = dbl_q ? {sgnQ, 63'h0} : {32'h0, sgnQ, 31'h0};
            end else if (ca == CLS_INF) begin
               wr = 1'b1;
               res = dbl_q ? {sgnQ, `DBL_INF_MAG} : {32'h0, sgnQ, `SGL_INF_MAG};
            end else begin
               wr = 1'b1;
               res = qWord;
               exc[`EXC_I] = qInex;                                    // [RULE20]
               exc[`EXC_O] = qOvf;
               exc[`EXC_U] = qUnf;
            end
         end
         default: ;
      endcase
   end

   wire anyExc   = (exc != 6'h0);
   wire vTrapped = exc[`EXC_V] && trapEnableBits[`EXC_V];
   wire ouiTrap  = |trapEnableBits[2:0];                               // [RULE3]
   wire trapNow  = ouiTrap || vTrapped || exc[`EXC_E]
                   || (exc[`EXC_Z] && trapEnableBits[`EXC_Z]);
   // Any exception blocks the write; double-to-single NaN default survives untrapped invalid
   wire writeOk  = wr && !trapNow && (!anyExc || (op_q == OP_CNVDS && exc == 6'h10)); // [RULE4] [RULE14] [RULE6]
   wire [4:0] needed = (op_q == OP_DIV) ? (dbl_q ? `DIVD_STATES : `DIVS_STATES) : `CNV_STATES;
   wire divReady = (op_q != OP_DIV) || divDone_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= ST_IDLE; op_q <= OP_NONE; dbl_q <= 1'b0; cnt_q <= '0;
         a_q <= '0; b_q <= '0; divStart_q <= 1'b0; divDone_q <= 1'b0;
         quot_q <= '0; rem_q <= 1'b0;
         busy <= 1'b0; done <= 1'b0; undefinedOp <= 1'b0; fpuTrap <= 1'b0;
         pcOut <= '0; exceptionCauseField <= '0; stickyFlagField <= '0;
         transferWe <= 1'b0; transferOut <= '0; singleDestWe <= 1'b0;
         singleDestOut <= '0; doubleDestWe <= 1'b0; doubleDestOut <= '0;
      end else begin
         done <= 1'b0; fpuTrap <= 1'b0; transferWe <= 1'b0;
         singleDestWe <= 1'b0; doubleDestWe <= 1'b0; divStart_q <= 1'b0;
         undefinedOp <= issue && (state_q == ST_IDLE) && cnvReserved;  // [RULE2]
         if (divDone) begin
            divDone_q <= 1'b1; quot_q <= divQuot; rem_q <= divRem;
         end
         case (state_q)
            ST_IDLE: if (start) begin
               state_q <= ST_RUN; busy <= 1'b1; cnt_q <= 5'd1;
               exceptionCauseField <= 6'h0;                            // [RULE21]
               pcOut <= pcIn + `PC_STEP;                               // [RULE21]
               dbl_q <= isDiv ? precisionSelect : 1'b1;
               divDone_q <= 1'b0;
               if (isCnvDs) begin
                  op_q <= OP_CNVDS;
                  a_q  <= doubleSourcePair;                            // [RULE1]
               end else if (isCnvSd) begin
                  op_q <= OP_CNVSD;
                  a_q  <= {32'h0, transferIn};                         // [RULE9]
               end else begin
                  op_q <= OP_DIV;
                  divStart_q <= 1'b1;
                  a_q <= precisionSelect ? doubleDestPair : {32'h0, singleDestReg};  // [RULE12]
                  b_q <= precisionSelect ? doubleSourcePair : {32'h0, singleSourceReg}; // [RULE13]
               end
            end
            ST_RUN: begin
               if (cnt_q < needed) cnt_q <= cnt_q + 5'd1;              // [RULE1] [RULE12] [RULE13]
               if (cnt_q >= needed - 5'd1 && divReady) state_q <= ST_FINISH;
            end
            ST_FINISH: begin
               state_q <= ST_IDLE; busy <= 1'b0; done <= 1'b1;
               exceptionCauseField <= exc;                             // [RULE4] [RULE14]
               stickyFlagField <= stickyFlagField | exc[4:0];          // [RULE22]
               fpuTrap <= trapNow;                                     // [RULE3] [RULE6]
               transferWe    <= writeOk && (op_q == OP_CNVDS);
               transferOut   <= res[31:0];
               singleDestWe  <= writeOk && (op_q == OP_DIV) && !dbl_q;
               singleDestOut <= res[31:0];
               doubleDestWe  <= writeOk && (op_q == OP_CNVSD || (op_q == OP_DIV && dbl_q));
               doubleDestOut <= res;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
endmodule

// file: fp_cdu_chk.sv
// Purpose: port-level assertions for the convert/divide slice
// Assumes: decoder holds opcode and modes while busy
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
module fp_cdu_chk (
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        issue,
   input wire logic [15:0] opcode,
   input wire logic        precisionSelect,
   input wire logic [4:0]  trapEnableBits,
   input wire logic [31:0] pcIn,
   input wire logic        busy,
   input wire logic        done,
   input wire logic        undefinedOp,
   input wire logic        fpuTrap,
   input wire logic [31:0] pcOut,
   input wire logic [5:0]  exceptionCauseField,
   input wire logic [4:0]  stickyFlagField,
   input wire logic        transferWe,
   input wire logic        singleDestWe,
   input wire logic        doubleDestWe
);
   wire isCnv = opcode[15:12] == 4'hF && (opcode[7:0] == 8'hBD || opcode[7:0] == 8'hAD);
   wire isDiv = opcode[15:12] == 4'hF && opcode[3:0] == 4'h3;
   wire take  = issue && !busy && (isDiv || (isCnv && precisionSelect));
   wire anyWe = transferWe || singleDestWe || doubleDestWe;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   pc_step_a: assert property (take |=> pcOut == $past(pcIn) + 32'h2
      && exceptionCauseField == 6'h00) else $error("pc or cause wrong");
   cnv_time_a: assert property (take && isCnv |=> !done ##1 !done ##1 done)
      else $error("cnv latency");
   reserved_op_a: assert property (issue && !busy && isCnv && !precisionSelect
      |=> undefinedOp && !busy && !done) else $error("reserved op taken");
   sdiv_time_a: assert property (take && isDiv && !precisionSelect
      |=> (!done)[*8] ##1 (!done)[*2] ##[1:100] done) else $error("sdiv latency");
   ddiv_time_a: assert property (take && isDiv && precisionSelect
      |=> (!done)[*8] ##1 (!done)[*8] ##1 (!done)[*6] ##[1:100] done)
      else $error("ddiv latency");
   trap_oui_a: assert property (done && |trapEnableBits[2:0] |-> fpuTrap)
      else $error("no trap");
   trap_nowrite_a: assert property (done && fpuTrap |-> !anyWe)
      else $error("write despite trap");
   error_nowrite_a: assert property (done && (exceptionCauseField[5] || exceptionCauseField[3])
      |-> !anyWe) else $error("write despite E or Z");
   sticky_or_a: assert property (done |-> stickyFlagField ==
      ($past(stickyFlagField) | exceptionCauseField[4:0])) else $error("sticky merge wrong");
   sticky_hold_a: assert property (!done |-> $stable(stickyFlagField))
      else $error("sticky moved");
   we_done_a: assert property (anyWe |-> done)
      else $error("write without done");
endmodule

// file: fp_regfile_model.sv
// Purpose: transfer register of the decoder/register file side
// Assumes: slice write wins over a load in the same cycle
// Notes:   drives the slice's transfer input
`timescale 1ns/1ps
module fp_regfile_model (
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        loadEn,
   input wire logic [31:0] loadVal,
   input wire logic        transferWe,
   input wire logic [31:0] transferOut,
   output logic [31:0]     transferReg
);
   always_ff @(posedge clk) begin
      if (srst) transferReg <= 32'h00000000;
      else if (transferWe) transferReg <= transferOut;
      else if (loadEn) transferReg <= loadVal;
   end
endmodule

// file: fp_convert_divide_unit_tb_top.sv
// Purpose: directed tests of the convert/divide slice
// Assumes: one op at a time
// Notes:   inputs change on the falling edge only
`include "fp_cdu_consts.svh"
`timescale 1ns/1ps
module fp_convert_divide_unit_tb_top;
   logic        clk, srst, issue, precisionSelect, denormalFlush, roundingSelect, loadEn;
   logic        busy, done, undefinedOp, fpuTrap, transferWe, singleDestWe, doubleDestWe;
   logic [15:0] opcode;
   logic [4:0]  trapEnableBits, stickyFlagField;
   logic [5:0]  exceptionCauseField;
   logic [31:0] pcIn, pcOut, xferReg, loadVal, singleSourceReg, singleDestReg;
   logic [31:0] transferOut, singleDestOut;
   logic [63:0] doubleSourcePair, doubleDestPair, doubleDestOut;
   int          err_total, n_tests;
   int          cycles = 0;
   fp_convert_divide_unit uut (.transferIn(xferReg), .*);
   fp_regfile_model partner (.transferReg(xferReg), .*);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Ceiling far above the longest run
   always @(posedge clk) begin
      cycles++;
      if (cycles == 8000) begin
         err_total++;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic doOp(input logic [15:0] op);
      int n;
      n = 0;
      opcode = op;
      issue = 1'b1;
      @(negedge clk);
      issue = 1'b0;
      while (done !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      if (n >= 300) chk("done", 1'b0, 1'b1);
   endtask
   task automatic judge(input logic [63:0] v, e, input logic w, ew, input logic [5:0] ec);
      chk("we", w, ew);
      chk("cause", exceptionCauseField, ec);
      chk("result", v, e);
   endtask
   task automatic load(input logic [31:0] v);
      loadEn = 1'b1;
      loadVal = v;
      @(negedge clk);
      loadEn = 1'b0;
   endtask
   task automatic cnvds(input logic [63:0] s, input logic [31:0] e, input logic ew,
                        input logic [5:0] ec, input logic r);
      doubleSourcePair = s;
      roundingSelect = r;
      pcIn = pcIn + 32'h10;
      doOp(16'hF0BD);
      chk("pc", pcOut, pcIn + 32'h2);
      judge(transferOut, e, transferWe, ew, ec);
   endtask
   task automatic cnvsd(input logic [31:0] s, input logic [63:0] e, input logic ew,
                        input logic [5:0] ec, input logic dn);
      denormalFlush = dn;
      load(s);
      doOp(16'hF0AD);
      judge(doubleDestOut, e, doubleDestWe, ew, ec);
   endtask
   task automatic sdiv(input logic [31:0] a, b, e, input logic ew, input logic [5:0] ec,
                       input logic r, dn);
      singleDestReg = a;
      singleSourceReg = b;
      roundingSelect = r;
      denormalFlush = dn;
      doOp(16'hF103);
      judge(singleDestOut, e, singleDestWe, ew, ec);
   endtask
   task automatic t_reset();
      chk("busy", busy, 1'b0);
      chk("sticky", stickyFlagField, 5'h00);
      $display("end reset test");
   endtask
   task automatic t_cnvds();
      precisionSelect = 1'b1;
      cnvds(64'h3FF0000000000000, 32'h3F800000, 1'b1, 6'h00, 1'b0);
      cnvds(64'h7FF0000000000000, `SGL_POS_INF, 1'b1, 6'h00, 1'b0);
      cnvds(64'hFFF0000000000000, `SGL_NEG_INF, 1'b1, 6'h00, 1'b0);
      cnvds(64'h7FF0000000000001, `SGL_QNAN, 1'b1, 6'h00, 1'b0);
      cnvds(64'h7FF8000000000000, `SGL_QNAN, 1'b1, 6'h10, 1'b0);
      cnvds(64'h3FF0000018000000, 32'h3F800001, 1'b0, 6'h01, 1'b0);
      cnvds(64'h3FF0000018000000, 32'h3F800000, 1'b0, 6'h01, 1'b1);
      $display("end narrowing test");
   endtask
   task automatic t_reserved();
      precisionSelect = 1'b0;
      for (int i = 0; i < 2; i++) begin
         opcode = i ? 16'hF0AD : 16'hF0BD;
         issue = 1'b1;
         @(negedge clk);
         issue = 1'b0;
         chk("undefined", undefinedOp, 1'b1);
         chk("busy", busy, 1'b0);
         @(negedge clk);
      end
      $display("end reserved test");
   endtask
   task automatic t_cnvsd();
      precisionSelect = 1'b1;
      cnvsd(32'h3F800000, 64'h3FF0000000000000, 1'b1, 6'h00, 1'b0);
      cnvsd(32'hFF800000, 64'hFFF0000000000000, 1'b1, 6'h00, 1'b0);
      cnvsd(32'h80000000, 64'h8000000000000000, 1'b1, 6'h00, 1'b0);
      cnvsd(32'h7F800001, `DBL_QNAN, 1'b1, 6'h00, 1'b0);
      cnvsd(32'h7FC00000, 64'h0, 1'b0, 6'h10, 1'b0);
      cnvsd(32'h00000001, 64'h0, 1'b0, 6'h20, 1'b0);
      cnvsd(32'h00000001, 64'h0, 1'b1, 6'h00, 1'b1);
      $display("end widening test");
   endtask
   task automatic t_sdiv();
      precisionSelect = 1'b0;
      sdiv(32'h40C00000, 32'h40000000, 32'h40400000, 1'b1, 6'h00, 1'b0, 1'b0);
      sdiv(32'h3F800000, 32'h40400000, 32'h3EAAAAAB, 1'b0, 6'h01, 1'b0, 1'b0);
      sdiv(32'h3F800000, 32'h40400000, 32'h3EAAAAAA, 1'b0, 6'h01, 1'b1, 1'b0);
      sdiv(32'h3F800000, 32'h00000000, 32'h0, 1'b0, 6'h08, 1'b0, 1'b0);
      sdiv(32'h00000000, 32'h00000000, 32'h0, 1'b0, 6'h10, 1'b0, 1'b0);
      sdiv(32'hFF800000, 32'h00000000, 32'hFF800000, 1'b1, 6'h00, 1'b0, 1'b0);
      sdiv(32'h7F800000, 32'h7F800000, 32'h0, 1'b0, 6'h10, 1'b0, 1'b0);
      sdiv(32'h3F800000, 32'hFF800000, 32'h80000000, 1'b1, 6'h00, 1'b0, 1'b0);
      sdiv(32'h7F800000, 32'hBF800000, 32'hFF800000, 1'b1, 6'h00, 1'b0, 1'b0);
      sdiv(32'h7FC00000, 32'h7F800001, 32'h0, 1'b0, 6'h10, 1'b0, 1'b0);
      sdiv(32'h7F800001, 32'h3F800000, `SGL_QNAN, 1'b1, 6'h00, 1'b0, 1'b0);
      sdiv(32'h00000001, 32'h3F800000, 32'h0, 1'b0, 6'h20, 1'b0, 1'b0);
      sdiv(32'h00000001, 32'h3F800000, 32'h0, 1'b1, 6'h00, 1'b0, 1'b1);
      $display("end single divide test");
   endtask
   task automatic t_ddiv();
      precisionSelect = 1'b1;
      roundingSelect = 1'b0;
      doubleDestPair = 64'h4008000000000000;
      doubleSourcePair = 64'h4000000000000000;
      doOp(16'hF203);
      judge(doubleDestOut, 64'h3FF8000000000000, doubleDestWe, 1'b1, 6'h00);
      $display("end double divide test");
   endtask
   task automatic t_trap();
      precisionSelect = 1'b1;
      load(32'h0BADF00D);
      trapEnableBits = 5'h04;
      cnvds(64'h3FF0000000000000, 32'h3F800000, 1'b0, 6'h00, 1'b0);
      chk("trap", fpuTrap, 1'b1);
      trapEnableBits = 5'h10;
      cnvds(64'h7FF8000000000000, `SGL_QNAN, 1'b0, 6'h10, 1'b0);
      chk("trap", fpuTrap, 1'b1);
      @(negedge clk);
      chk("transfer kept", xferReg, 32'h0BADF00D);
      trapEnableBits = 5'h00;
      $display("end trap test");
   endtask
   initial begin
      srst = 1'b1;
      {issue, loadEn, denormalFlush, roundingSelect} = 4'h0;
      precisionSelect = 1'b1;
      opcode = 16'h0000;
      trapEnableBits = 5'h00;
      {pcIn, loadVal, singleSourceReg, singleDestReg} = 128'h0;
      {doubleSourcePair, doubleDestPair} = 128'h0;
      err_total = 0;
      n_tests = 0;
      repeat (10) @(negedge clk);
      srst = 1'b0;
      @(negedge clk);
      t_reset();
      t_cnvds();
      t_reserved();
      t_cnvsd();
      t_sdiv();
      t_ddiv();
      t_trap();
      summarize();
   end
endmodule
bind fp_convert_divide_unit fp_cdu_chk chk (.*);
